// ===== inc/uart_setup_pkg.sv
package uart_setup_pkg;

   // bus and register widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFF_SERIAL_OUTPUT_LEVEL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SERIAL_OUTPUT_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RX_FILTER_ENABLE     = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_ERROR_CLEAR_TRIGGER  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK_LOW         = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_INT_PRIORITY_LOW     = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_INT_PRIORITY_HIGH    = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_PORT1_OUTPUT_DATA    = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_PORT1_DIRECTION      = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_CHANNEL_START        = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_INT_REQUEST_LOW      = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_RX_STATUS            = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_CHANNEL_STOP         = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_CHANNEL_CONTROL      = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_CHANNEL_STATUS       = 8'h38;

   // field positions
   localparam int TX_CHANNEL_BIT   = 0;
   localparam int OVERRUN_BIT      = 0;
   localparam int PARITY_BIT       = 1;
   localparam int FRAMING_BIT      = 2;
   localparam int ERROR_BITS       = 3;
   localparam int INT_TX_END_BIT   = 3;
   localparam int INT_RX_END_BIT   = 4;
   localparam int INT_RX_ERROR_BIT = 5;
   localparam int INT_SOURCES      = 3;
   localparam int INT_BASE_BIT     = INT_TX_END_BIT;
   localparam int TX_PIN_BIT       = 2;
   localparam int RX_PIN_BIT       = 1;
   localparam int CHANNELS         = 2;

   // reset values
   localparam logic [REG_W-1:0] RST_OUTPUT_LEVEL  = 8'h03;
   localparam logic [REG_W-1:0] RST_OUTPUT_ENABLE = 8'h00;
   localparam logic [REG_W-1:0] RST_FILTER_ENABLE = 8'h00;
   localparam logic [REG_W-1:0] RST_INT_MASK      = 8'hFF;
   localparam logic [REG_W-1:0] RST_PRIORITY      = 8'hFF;
   localparam logic [REG_W-1:0] RST_PORT_DATA     = 8'h00;
   localparam logic [REG_W-1:0] RST_PORT_DIR      = 8'hFF;
   localparam logic [1:0]       LOWEST_PRIORITY   = 2'h3;

   // receive pin noise filter: samples that must agree
   localparam int FILTER_LEN = 3;

   // events from the serial engines, one-cycle pulses
   typedef struct packed {
      logic framing;
      logic parity;
      logic overrun;
      logic rx_end;
      logic tx_end;
   } serial_event_t;

endpackage

// ===== src/rx_noise_filter.sv
`timescale 1ns/1ns
module rx_noise_filter
   import uart_setup_pkg::*;
(
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rstn_in,
   // pin and control
   input  wire logic pin_in,
   input  wire logic filter_enable_in,
   // cleaned level
   output logic      level_out
);

   logic                  sync_first;
   logic                  sync_second;
   logic [FILTER_LEN-1:0] history;

   // two-stage synchroniser, idle line is high
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_first  <= 1'b1;
         sync_second <= 1'b1;
      end else begin
         sync_first  <= pin_in;
         sync_second <= sync_first;
      end
   end

   // sample history for the filter
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         history <= '1;
      end else begin
         history <= {history[FILTER_LEN-2:0], sync_second};
      end
   end

   // filtered level moves only on agreeing samples; costs FILTER_LEN cycles of latency
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         level_out <= 1'b1;
      end else if (!filter_enable_in) begin
         level_out <= sync_second;
      end else if (&history) begin
         level_out <= 1'b1;
      end else if (~|history) begin
         level_out <= 1'b0;
      end
   end

endmodule

// ===== src/uart_channel_setup_control.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module uart_channel_setup_control
   import uart_setup_pkg::*;
(
   // clock and reset
   input  wire logic                clock_in,
   input  wire logic                rstn_in,
   // apb slave
   input  wire logic                psel_in,
   input  wire logic                penable_in,
   input  wire logic                pwrite_in,
   input  wire logic [ADDR_W-1:0]   paddr_in,
   input  wire logic [DATA_W-1:0]   pwdata_in,
   input  wire logic [3:0]          pstrb_in,
   output logic      [DATA_W-1:0]   prdata_out,
   output logic                     pready_out,
   output logic                     pslverr_out,
   // serial engine side
   input  wire serial_event_t       event_in,
   input  wire logic                tx_serial_in,
   output logic                     rx_serial_out,
   output logic      [CHANNELS-1:0] channel_enabled_out,
   output logic      [CHANNELS-1:0] channel_start_out,
   output logic      [CHANNELS-1:0] receive_enable_out,
   // pins, enables low while driving
   output logic                     tx_pin_out,
   output logic                     tx_pin_oe_n_out,
   input  wire logic                rx_pin_in,
   output logic                     rx_pin_out,
   output logic                     rx_pin_oe_n_out,
   // interrupt
   output logic                     irq_out,
   output logic      [1:0]          irq_priority_out
);

   logic [REG_W-1:0]      serial_output_level;
   logic [REG_W-1:0]      serial_output_enable;
   logic [REG_W-1:0]      receive_noise_filter_enable;
   logic [REG_W-1:0]      interrupt_mask_low;
   logic [REG_W-1:0]      interrupt_priority_low_bits;
   logic [REG_W-1:0]      interrupt_priority_high_bits;
   logic [REG_W-1:0]      port1_output_data;
   logic [REG_W-1:0]      port1_direction;
   logic [ERROR_BITS-1:0] error_flags;
   logic [INT_SOURCES-1:0] int_request;
   logic [CHANNELS-1:0]   channel_enabled_status;
   logic [CHANNELS-1:0]   receive_enable_bit;

   logic                  setup_phase;
   logic                  write_strobe;
   logic [REG_W-1:0]      wdata;
   logic                  addr_hit;
   logic [REG_W-1:0]      next_rdata;
   logic [ERROR_BITS-1:0] error_set;
   logic [ERROR_BITS-1:0] error_clear;
   logic [INT_SOURCES-1:0] int_set;
   logic [INT_SOURCES-1:0] int_clear;
   logic [INT_SOURCES-1:0] int_pending;
   logic [CHANNELS-1:0]   start_trigger;
   logic [CHANNELS-1:0]   stop_trigger;
   logic                  serial_level;
   logic [1:0]            next_priority;

   // bus phases; only the low byte lane carries register data
   assign setup_phase  = psel_in & ~penable_in;
   assign write_strobe = psel_in & penable_in & pready_out & pwrite_in & pstrb_in[0];
   assign wdata        = pwdata_in[REG_W-1:0];

   // read decode
   always_comb begin
      addr_hit   = 1'b1;
      next_rdata = '0;
      if (paddr_in == OFF_SERIAL_OUTPUT_LEVEL) begin
         next_rdata = serial_output_level;
      end else if (paddr_in == OFF_SERIAL_OUTPUT_ENABLE) begin
         next_rdata = serial_output_enable;
      end else if (paddr_in == OFF_RX_FILTER_ENABLE) begin
         next_rdata = receive_noise_filter_enable;
      end else if (paddr_in == OFF_ERROR_CLEAR_TRIGGER) begin
         next_rdata = '0;
      end else if (paddr_in == OFF_INT_MASK_LOW) begin
         next_rdata = interrupt_mask_low;
      end else if (paddr_in == OFF_INT_PRIORITY_LOW) begin
         next_rdata = interrupt_priority_low_bits;
      end else if (paddr_in == OFF_INT_PRIORITY_HIGH) begin
         next_rdata = interrupt_priority_high_bits;
      end else if (paddr_in == OFF_PORT1_OUTPUT_DATA) begin
         next_rdata = port1_output_data;
      end else if (paddr_in == OFF_PORT1_DIRECTION) begin
         next_rdata = port1_direction;
      end else if (paddr_in == OFF_CHANNEL_START) begin
         next_rdata = '0;
      end else if (paddr_in == OFF_INT_REQUEST_LOW) begin
         next_rdata[INT_BASE_BIT +: INT_SOURCES] = int_request;
      end else if (paddr_in == OFF_RX_STATUS) begin
         next_rdata[ERROR_BITS-1:0] = error_flags;
      end else if (paddr_in == OFF_CHANNEL_STOP) begin
         next_rdata = '0;
      end else if (paddr_in == OFF_CHANNEL_CONTROL) begin
         next_rdata[CHANNELS-1:0] = receive_enable_bit;
      end else if (paddr_in == OFF_CHANNEL_STATUS) begin
         next_rdata[CHANNELS-1:0] = channel_enabled_status;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // one wait-free access phase; answer prepared in the setup cycle
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= '0;
      end else begin
         pready_out  <= setup_phase;
         pslverr_out <= setup_phase & ~addr_hit;
         if (setup_phase && !pwrite_in) begin
            prdata_out <= {{(DATA_W-REG_W){1'b0}}, next_rdata};
         end else begin
            prdata_out <= '0;
         end
      end
   end

   // transmit output value and enable
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial_output_level  <= RST_OUTPUT_LEVEL;
         serial_output_enable <= RST_OUTPUT_ENABLE;
      end else if (write_strobe) begin
         if (paddr_in == OFF_SERIAL_OUTPUT_LEVEL) begin
            serial_output_level <= wdata;
         end else if (paddr_in == OFF_SERIAL_OUTPUT_ENABLE) begin
            serial_output_enable <= wdata;
         end
      end
   end

   // receive filter enable
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         receive_noise_filter_enable <= RST_FILTER_ENABLE;
      end else if (write_strobe && paddr_in == OFF_RX_FILTER_ENABLE) begin
         receive_noise_filter_enable <= wdata;
      end
   end

   // interrupt mask and priority bits
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         interrupt_mask_low           <= RST_INT_MASK;
         interrupt_priority_low_bits  <= RST_PRIORITY;
         interrupt_priority_high_bits <= RST_PRIORITY;
      end else if (write_strobe) begin
         if (paddr_in == OFF_INT_MASK_LOW) begin
            interrupt_mask_low <= wdata;
         end else if (paddr_in == OFF_INT_PRIORITY_LOW) begin
            interrupt_priority_low_bits <= wdata;
         end else if (paddr_in == OFF_INT_PRIORITY_HIGH) begin
            interrupt_priority_high_bits <= wdata;
         end
      end
   end

   // port data and direction
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         port1_output_data <= RST_PORT_DATA;
         port1_direction   <= RST_PORT_DIR;
      end else if (write_strobe) begin
         if (paddr_in == OFF_PORT1_OUTPUT_DATA) begin
            port1_output_data <= wdata;
         end else if (paddr_in == OFF_PORT1_DIRECTION) begin
            port1_direction <= wdata;
         end
      end
   end

   // receive enable per channel
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         receive_enable_bit <= '0;
      end else if (write_strobe && paddr_in == OFF_CHANNEL_CONTROL) begin
         receive_enable_bit <= wdata[CHANNELS-1:0];
      end
   end

   // error flags: clear trigger is decoded, never stored
   assign error_set[FRAMING_BIT] = event_in.framing;
   assign error_set[PARITY_BIT]  = event_in.parity;
   assign error_set[OVERRUN_BIT] = event_in.overrun;
   assign error_clear = (write_strobe && paddr_in == OFF_ERROR_CLEAR_TRIGGER) ?
                        wdata[ERROR_BITS-1:0] : '0;

   // a new error in the clearing cycle survives the clear
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         error_flags <= '0;
      end else begin
         error_flags[FRAMING_BIT] <= error_set[FRAMING_BIT] |
                                     (error_flags[FRAMING_BIT] & ~error_clear[FRAMING_BIT]);
         error_flags[PARITY_BIT]  <= error_set[PARITY_BIT] |
                                     (error_flags[PARITY_BIT] & ~error_clear[PARITY_BIT]);
         error_flags[OVERRUN_BIT] <= error_set[OVERRUN_BIT] |
                                     (error_flags[OVERRUN_BIT] & ~error_clear[OVERRUN_BIT]);
      end
   end

   // interrupt sources in register order: tx end, rx end, rx error
   assign int_set[INT_TX_END_BIT-INT_BASE_BIT]   = event_in.tx_end;
   assign int_set[INT_RX_END_BIT-INT_BASE_BIT]   = event_in.rx_end;
   assign int_set[INT_RX_ERROR_BIT-INT_BASE_BIT] = event_in.framing | event_in.parity | event_in.overrun;
   assign int_clear = (write_strobe && paddr_in == OFF_INT_REQUEST_LOW) ?
                      wdata[INT_BASE_BIT +: INT_SOURCES] : '0;

   // sticky request flags, write one to clear, set wins
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         int_request <= '0;
      end else begin
         int_request <= int_set | (int_request & ~int_clear);
      end
   end

   assign int_pending = int_request & ~interrupt_mask_low[INT_BASE_BIT +: INT_SOURCES];

   // best level among pending unmasked sources; ties go to the lower bit
   always_comb begin
      next_priority = LOWEST_PRIORITY;
      for (int s = INT_SOURCES - 1; s >= 0; s--) begin
         if (int_pending[s] &&
             {interrupt_priority_high_bits[INT_BASE_BIT + s],
              interrupt_priority_low_bits[INT_BASE_BIT + s]} <= next_priority) begin
            next_priority = {interrupt_priority_high_bits[INT_BASE_BIT + s],
                             interrupt_priority_low_bits[INT_BASE_BIT + s]};
         end
      end
   end

   // level interrupt and its priority
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_out          <= 1'b0;
         irq_priority_out <= LOWEST_PRIORITY;
      end else begin
         irq_out          <= |int_pending;
         irq_priority_out <= next_priority;
      end
   end

   // start and stop triggers, decoded from the write only
   assign start_trigger = (write_strobe && paddr_in == OFF_CHANNEL_START) ?
                          wdata[CHANNELS-1:0] : '0;
   assign stop_trigger  = (write_strobe && paddr_in == OFF_CHANNEL_STOP) ?
                          wdata[CHANNELS-1:0] : '0;

   // channel enters communication wait; start wins over stop
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         channel_enabled_status <= '0;
         channel_start_out      <= '0;
      end else begin
         channel_enabled_status <= start_trigger | (channel_enabled_status & ~stop_trigger);
         channel_start_out      <= start_trigger;
      end
   end

   // registered copies for the engines
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         channel_enabled_out <= '0;
         receive_enable_out  <= '0;
      end else begin
         channel_enabled_out <= start_trigger | (channel_enabled_status & ~stop_trigger);
         receive_enable_out  <= receive_enable_bit;
      end
   end

   // engine data only while output enabled and running, else the held level
   assign serial_level = (serial_output_enable[TX_CHANNEL_BIT] && channel_enabled_status[TX_CHANNEL_BIT]) ?
                         tx_serial_in : serial_output_level[TX_CHANNEL_BIT];

   // pins: latch gates the serial level, direction bit is the active-low enable
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_pin_out      <= 1'b0;
         tx_pin_oe_n_out <= 1'b1;
         rx_pin_out      <= 1'b0;
         rx_pin_oe_n_out <= 1'b1;
      end else begin
         tx_pin_out      <= port1_output_data[TX_PIN_BIT] & serial_level;
         tx_pin_oe_n_out <= port1_direction[TX_PIN_BIT];
         rx_pin_out      <= port1_output_data[RX_PIN_BIT];
         rx_pin_oe_n_out <= port1_direction[RX_PIN_BIT];
      end
   end

   // receive pin cleaning
   rx_noise_filter rx_filter (
      .clock_in         (clock_in),
      .rstn_in          (rstn_in),
      .pin_in           (rx_pin_in),
      .filter_enable_in (receive_noise_filter_enable[0]),
      .level_out        (rx_serial_out)
   );

endmodule

// ===== sim/uart_setup_sva.sv
`timescale 1ns/1ns
module uart_setup_sva
   import uart_setup_pkg::*;
(
   // clock, reset and bus
   input  wire logic                clock_in,
   input  wire logic                rstn_in,
   input  wire logic                psel_in,
   input  wire logic                penable_in,
   input  wire logic                pwrite_in,
   input  wire logic [DATA_W-1:0]   prdata_out,
   input  wire logic                pready_out,
   input  wire logic                pslverr_out,
   // pins and channel state
   input  wire logic                rx_pin_in,
   input  wire logic                rx_serial_out,
   input  wire logic                tx_pin_oe_n_out,
   input  wire logic [CHANNELS-1:0] channel_enabled_out,
   input  wire logic [CHANNELS-1:0] channel_start_out,
   // interrupt
   input  wire logic                irq_out,
   input  wire logic [1:0]          irq_priority_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   // completed write: the edge at which registers change
   logic wr_done;
   assign wr_done = psel_in && penable_in && pwrite_in && pready_out;

   // bus setup cycle
   sequence setup_s;
      psel_in && !penable_in;
   endsequence
   // eight equal samples outlast both sync and filter
   sequence pin_quiet_s;
      (rx_pin_in == $past(rx_pin_in)) [*7];
   endsequence

   ready_after_setup_a: assert property (setup_s |=> pready_out)
      else $error("no ready after setup");
   ready_single_a: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   error_with_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("slave error outside access");
   rdata_idle_a: assert property (!pready_out |-> prdata_out == '0)
      else $error("read data outside access");
   idle_priority_a: assert property (!irq_out |-> irq_priority_out == 2'h3)
      else $error("priority not lowest without request");
   start_sets_enable_a: assert property ((channel_start_out & ~channel_enabled_out) == '0)
      else $error("start without enabled status");
   start_from_write_a: assert property (|channel_start_out |-> $past(wr_done) ##1 channel_start_out == '0)
      else $error("start pulse without write or too long");
   rx_follows_pin_a: assert property (pin_quiet_s |-> rx_serial_out == rx_pin_in)
      else $error("receive path does not follow quiet pin");
   mode_from_write_a: assert property ($changed(tx_pin_oe_n_out) |-> $past(wr_done, 2))
      else $error("pin mode changed without write");
endmodule

// ===== sim/uart_far_peer.sv
`timescale 1ns/1ns
module uart_far_peer (
   // bench clock
   input  wire logic clock_in,
   // line towards the receive pin
   output logic      rx_line_out
);
   // the far end idles at mark level between characters
   initial rx_line_out = 1'b1;

   // spike or break the line for n clocks, then back to mark
   task automatic pulse_low(input int n);
      @(posedge clock_in);
      rx_line_out <= 1'b0;
      repeat (n) @(posedge clock_in);
      rx_line_out <= 1'b1;
   endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import uart_setup_pkg::*;
   // bench signals
   logic                clock_in, rstn_in, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0]   paddr;
   logic [DATA_W-1:0]   pwdata, prdata, rd;
   logic [3:0]          pstrb;
   logic                tx_serial, rx_serial, rx_pin, tx_pin, tx_oe_n, rx_pout, rx_oe_n, irq;
   logic [1:0]          prio;
   logic [CHANNELS-1:0] ch_en, ch_start, rx_en;
   serial_event_t       ev;
   logic [2:0]          st, p, c, m, pl, ph, r;
   int                  fails, n_checks;
   // {offset, reset value}; trigger registers read zero
   localparam logic [15:0] RST_TAB [10] = '{16'h0003, 16'h0400, 16'h0800, 16'h0C00, 16'h10FF,
                                            16'h14FF, 16'h18FF, 16'h1C00, 16'h20FF, 16'h2400};

   uart_channel_setup_control i_uart_channel_setup_control (
      .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .event_in(ev),
      .tx_serial_in(tx_serial), .rx_serial_out(rx_serial), .channel_enabled_out(ch_en),
      .channel_start_out(ch_start), .receive_enable_out(rx_en), .tx_pin_out(tx_pin),
      .tx_pin_oe_n_out(tx_oe_n), .rx_pin_in(rx_pin), .rx_pin_out(rx_pout),
      .rx_pin_oe_n_out(rx_oe_n), .irq_out(irq), .irq_priority_out(prio));
   uart_far_peer i_uart_far_peer (.clock_in(clock_in), .rx_line_out(rx_pin));

   // 50 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   // run is a few hundred cycles; 20000 means a hang
   initial begin
      #400000;
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      report_and_stop();
   end

   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   // one transfer; an extra edge after release keeps strobes from double assignment
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      chk(32'(pready), 32'h1, "bus ready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      apb(1'b0, a, '0);
      chk(rd, e, "register read");
   endtask

   // spike on the receive line, watch whether the receive path shows it
   task automatic glitch(input int n, input logic exp_low);
      logic low;
      low = 1'b0;
      fork
         i_uart_far_peer.pulse_low(n);
         repeat (n + 10) begin
            @(posedge clock_in);
            low = low | !rx_serial;
         end
      join
      chk(32'(low), 32'(exp_low), "receive spike");
   endtask

   // best (lowest) level among pending unmasked sources
   function automatic logic [1:0] best_level(input logic [2:0] req, msk, lo, hi);
      logic [1:0] lv;
      lv = LOWEST_PRIORITY;
      for (int i = 0; i < INT_SOURCES; i++)
         if (req[i] && !msk[i] && {hi[i], lo[i]} < lv) lv = {hi[i], lo[i]};
      return lv;
   endfunction

   // main sequence
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = 4'hF;
      ev = '0; tx_serial = 1'b1; rstn_in = 1'b0; fails = 0; n_checks = 0; st = '0;
      void'($urandom(90));
      tick(8);
      rstn_in <= 1'b1;
      foreach (RST_TAB[i]) rchk(RST_TAB[i][15:8], 32'(RST_TAB[i][7:0]));
      rchk(8'h3C, '0);
      chk(32'(err), 32'h1, "unmapped error");
      pstrb <= 4'hE;
      apb(1'b1, OFF_SERIAL_OUTPUT_LEVEL, '0);
      pstrb <= 4'hF;
      rchk(OFF_SERIAL_OUTPUT_LEVEL, 32'h3);
      // receive enable, four clocks, then start both channels
      apb(1'b1, OFF_CHANNEL_CONTROL, 32'h2);
      tick(4);
      chk(32'(rx_en), 32'h2, "receive enable out");
      apb(1'b1, OFF_CHANNEL_START, 32'h3);
      rchk(OFF_CHANNEL_START, '0);
      rchk(OFF_CHANNEL_STATUS, 32'h3);
      chk(32'(ch_en), 32'h3, "enabled out");
      apb(1'b1, OFF_CHANNEL_STOP, 32'h2);
      apb(1'b1, OFF_CHANNEL_START, 32'h0);
      rchk(OFF_CHANNEL_STATUS, 32'h1);
      // transmit pin as output at data 1, receive pin as input
      apb(1'b1, OFF_PORT1_OUTPUT_DATA, 32'h06);
      apb(1'b1, OFF_PORT1_DIRECTION, 32'hFB);
      tick(2);
      chk(32'({tx_oe_n, rx_oe_n, tx_pin, rx_pout}), 32'h7, "pin modes");
      apb(1'b1, OFF_SERIAL_OUTPUT_LEVEL, 32'h2);
      tick(2);
      chk(32'(tx_pin), 32'h0, "level low");
      apb(1'b1, OFF_SERIAL_OUTPUT_LEVEL, 32'h3);
      apb(1'b1, OFF_SERIAL_OUTPUT_ENABLE, 32'h1);
      repeat (8) begin
         tx_serial <= 1'($urandom);
         tick(2);
         chk(32'(tx_pin), 32'(tx_serial), "tx data");
      end
      apb(1'b1, OFF_SERIAL_OUTPUT_ENABLE, 32'h0);
      tx_serial <= 1'b0;
      tick(2);
      chk(32'(tx_pin), 32'h1, "output stopped");
      apb(1'b1, OFF_PORT1_OUTPUT_DATA, 32'h00);
      tick(2);
      chk(32'({tx_pin, rx_pout}), 32'h0, "port data low");
      // error flags: set by events, cleared per written one
      for (int i = 0; i < 6; i++) begin
         p = (i < 2) ? 3'h7 : 3'($urandom);
         c = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
         ev <= serial_event_t'({p, 2'b00});
         tick(1);
         ev <= '0;
         st = st | p;
         rchk(OFF_RX_STATUS, 32'(st));
         apb(1'b1, OFF_ERROR_CLEAR_TRIGGER, 32'(c));
         st = st & ~c;
         rchk(OFF_RX_STATUS, 32'(st));
      end
      // requests, masks and priorities, corners first
      for (int i = 0; i < 8; i++) begin
         m = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
         r = (i < 2) ? 3'h7 : 3'($urandom);
         pl = 3'($urandom);
         ph = 3'($urandom);
         apb(1'b1, OFF_INT_REQUEST_LOW, 32'h38);
         apb(1'b1, OFF_INT_MASK_LOW, 32'({m, 3'h0}));
         apb(1'b1, OFF_INT_PRIORITY_LOW, 32'({pl, 3'h0}));
         apb(1'b1, OFF_INT_PRIORITY_HIGH, 32'({ph, 3'h0}));
         ev <= serial_event_t'({r[2], 2'b00, r[1], r[0]});
         tick(1);
         ev <= '0;
         tick(2);
         chk(32'({irq, prio}), 32'({|(r & ~m), best_level(r, m, pl, ph)}), "irq out");
         rchk(OFF_INT_REQUEST_LOW, 32'({r, 3'h0}));
      end
      apb(1'b1, OFF_INT_REQUEST_LOW, 32'h38);
      tick(2);
      chk(32'(irq), 32'h0, "irq cleared");
      // spikes pass unfiltered; when filtered a one-clock spike is removed, a six-clock pulse passes
      glitch(1, 1'b1);
      apb(1'b1, OFF_RX_FILTER_ENABLE, 32'h1);
      glitch(1, 1'b0);
      glitch(6, 1'b1);
      report_and_stop();
   end
endmodule

bind uart_channel_setup_control uart_setup_sva i_uart_setup_sva (
   .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .rx_pin_in(rx_pin_in), .rx_serial_out(rx_serial_out),
   .tx_pin_oe_n_out(tx_pin_oe_n_out), .channel_enabled_out(channel_enabled_out),
   .channel_start_out(channel_start_out), .irq_out(irq_out), .irq_priority_out(irq_priority_out));
